// ===== design/fifo_map.vh
// constants for the shared byte queue: register offsets, field positions,
// reset values and sizes; included by the queue's top design file, by the port checker and by the bench.
// assumes nothing beyond a Verilog-2005 preprocessor.
// Function
// - one byte queue, 512 entries, both directions
// - depth reducible to 255, shorter parameters
// - depth select 1 gives 255, else 512
// - state machine may read/write during commands
// - flush resets pointers, clears occupancy count
// - count tracks writes and reads, host readable
// - full depth: count high bits in control
// - threshold = reg 02h bit 2, reg 03h
// - one threshold serves both alerts
// - near full when free space <= threshold
// - near empty when count <= threshold
// - write while full sets error flag
// - near empty rise interrupts when enabled
// - near full rise interrupts when enabled
`ifndef FIFO_MAP_VH
`define FIFO_MAP_VH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_CONTROL      8'h02
`define OFS_THRESH_LOW   8'h03
`define OFS_COUNT_LOW    8'h04
`define OFS_DATA         8'h05
`define OFS_IRQ_STATUS   8'h06
`define OFS_IRQ_ENABLE   8'h07

// ************************************************************
// field positions
// ************************************************************
`define CTL_DEPTH_SEL    7
`define CTL_NEAR_FULL    6
`define CTL_NEAR_EMPTY   5
`define CTL_FLUSH        4
`define CTL_THRESH_HI    2
`define IRQ_NEAR_EMPTY   0
`define IRQ_NEAR_FULL    1
`define IRQ_ERROR        2

// ************************************************************
// sizes and reset values
// ************************************************************
`define DEPTH_FULL       10'h200
`define DEPTH_SHORT      10'h0FF
`define THRESH_RESET     9'h008
`define ENABLE_RESET     3'h0

`endif

// ===== design/byte_ram.v
// byte storage array with one write port and one registered read port.
// assumes a single clock; read data appear one edge after the address.
`timescale 1ns/1ns
`default_nettype none

module byte_ram
#(
    parameter WIDTH = 8,
    parameter ABITS = 9
)
(
    input  wire             sys_clk,
    input  wire             wr_en,
    input  wire [ABITS-1:0] wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    input  wire [ABITS-1:0] rd_addr,
    output reg  [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:(1<<ABITS)-1];

    always @(posedge sys_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end

endmodule

`default_nettype wire

// ===== design/pair_buffer.v
// two-entry elastic buffer with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset; flush empties it.
`timescale 1ns/1ns
`default_nettype none

module pair_buffer
#(
    parameter WIDTH = 8
)
(
    input  wire             sys_clk,
    input  wire             reset,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [1:0]       fill
);

    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg [1:0]       level;
    wire            take;
    wire            give;

    assign in_ready  = (level != 2'h2);
    assign out_valid = (level != 2'h0);
    assign out_data  = slot0;
    assign fill      = level;
    assign take      = in_valid & in_ready;
    assign give      = out_valid & out_ready;

    always @(posedge sys_clk)
    begin
        if (reset || flush)
        begin
            level <= 2'h0;
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
        end
        else
        begin
            // slot0 is always the oldest word, so order is kept
            if (give)
                slot0 <= (level == 2'h2) ? slot1 : in_data;
            else if (take && level == 2'h0)
                slot0 <= in_data;
            if (take && (level - {1'b0, give}) == 2'h1)
                slot1 <= in_data;
            level <= level + {1'b0, take} - {1'b0, give};
        end
    end

endmodule

`default_nettype wire

// ===== design/shared_byte_fifo.v
// shared byte queue between the host register port and the protocol
// state machine, with occupancy count, flush, alerts and interrupt pin.
// assumes host and state machine run on sys_clk; reset is synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_map.vh"

module shared_byte_fifo
#(
    parameter ABITS = 9
)
(
    input  wire       sys_clk,
    input  wire       reset,
    // host register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output wire [7:0] reg_rdata,
    output reg        reg_rdata_valid,
    // state machine write side
    input  wire       sm_wr_valid,
    output wire       sm_wr_ready,
    input  wire [7:0] sm_wr_data,
    // state machine read side
    input  wire       sm_fetch_en,
    output wire       sm_rd_valid,
    input  wire       sm_rd_ready,
    output wire [7:0] sm_rd_data,
    // interrupt pin, active high
    output wire       irq
);

    // ************************************************************
    // helper functions
    // ************************************************************
    function [9:0] capacity;
        input short_mode;
        begin
            capacity = short_mode ? `DEPTH_SHORT : `DEPTH_FULL;
        end
    endfunction

    function at_most;
        input [9:0] value;
        input [8:0] limit;
        begin
            at_most = (value <= {1'b0, limit});
        end
    endfunction

    // one decoder for every register strobe
    function hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = strobe & (addr == offset);
        end
    endfunction

    // room left stops at zero: a queue shrunk below its fill reads as full
    // instead of wrapping to a huge free space
    function [9:0] room_left;
        input [9:0] size;
        input [9:0] used;
        begin
            room_left = (used >= size) ? 10'h000 : size - used;
        end
    endfunction

    // ************************************************************
    // reset values
    // ************************************************************
    // the threshold reset value is split over two registers
    localparam [8:0] THRESH_INIT = `THRESH_RESET;
    localparam [2:0] ENABLE_INIT = `ENABLE_RESET;

    // ************************************************************
    // state
    // ************************************************************
    reg             depth_select;
    reg             thresh_hi;
    reg  [7:0]      queue_threshold_low;
    reg  [9:0]      occupancy_count;
    reg  [ABITS-1:0] wr_ptr;
    reg  [ABITS-1:0] rd_ptr;
    reg  [2:0]      irq_status_first;
    reg  [2:0]      irq_enable_first;
    reg             prev_near_full;
    reg             prev_near_empty;
    reg             sm_pending;
    reg             host_pending;
    reg  [7:0]      rdata_reg;

    // ************************************************************
    // decode
    // ************************************************************
    wire            host_wr_data;
    wire            host_rd_data;
    wire            flush_pointers;
    wire            wr_control;
    wire            wr_thresh_low;
    wire            wr_irq_status;
    wire            wr_irq_enable;
    wire [9:0]      cap;
    wire [8:0]      threshold;
    wire            is_full;
    wire            is_empty;
    wire            push_req;
    wire [7:0]      push_data;
    wire            do_push;
    wire            overflow_indication;
    wire            pop_host;
    wire            pop_sm;
    wire            do_pop;
    wire [1:0]      buf_fill;
    wire [7:0]      ram_q;
    wire            near_full_flag;
    wire            near_empty_flag;
    wire [2:0]      irq_set;
    wire [2:0]      irq_clr;
    wire [9:0]      free_space;
    wire            near_full_rise;
    wire            near_empty_rise;
    wire [7:0]      ctl_byte;

    assign wr_control     = hit(reg_wr, reg_addr, `OFS_CONTROL);
    assign wr_thresh_low  = hit(reg_wr, reg_addr, `OFS_THRESH_LOW);
    assign wr_irq_status  = hit(reg_wr, reg_addr, `OFS_IRQ_STATUS);
    assign wr_irq_enable  = hit(reg_wr, reg_addr, `OFS_IRQ_ENABLE);
    assign host_wr_data   = hit(reg_wr, reg_addr, `OFS_DATA);
    assign host_rd_data   = hit(reg_rd, reg_addr, `OFS_DATA);
    assign flush_pointers = wr_control & reg_wdata[`CTL_FLUSH];
    assign cap            = capacity(depth_select);
    assign threshold      = {thresh_hi, queue_threshold_low};
    assign is_full        = (occupancy_count >= cap);
    assign is_empty       = (occupancy_count == 10'h000);

    // the queue cannot tell which bytes a running command still needs;
    // keeping the host off the data port meanwhile is left to software

    // host writes take the port; the state machine waits a cycle
    assign sm_wr_ready    = ~host_wr_data;
    assign push_req       = host_wr_data | sm_wr_valid;
    assign push_data      = host_wr_data ? reg_wdata : sm_wr_data;
    assign do_push        = push_req & ~is_full & ~flush_pointers;
    assign overflow_indication = push_req & is_full;

    // prefetch only while the buffer surely has room for the late word
    assign pop_host = host_rd_data & ~is_empty & ~flush_pointers;
    assign pop_sm   = ~host_rd_data & sm_fetch_en & ~is_empty
                    & ~flush_pointers
                    & (({1'b0, buf_fill} + {2'b00, sm_pending}) < 3'h2);
    assign do_pop   = pop_host | pop_sm;

    // ************************************************************
    // alerts
    // ************************************************************
    assign free_space      = room_left(cap, occupancy_count);
    assign near_full_flag  = at_most(free_space, threshold);
    assign near_empty_flag = at_most(occupancy_count, threshold);

    // edges against last cycle's flag: a flag that stays up asks only once
    assign near_full_rise  = near_full_flag & ~prev_near_full;
    assign near_empty_rise = near_empty_flag & ~prev_near_empty;

    assign irq_set[`IRQ_NEAR_EMPTY] = near_empty_rise;
    assign irq_set[`IRQ_NEAR_FULL]  = near_full_rise;
    assign irq_set[`IRQ_ERROR]      = overflow_indication;
    assign irq_clr = wr_irq_status ? reg_wdata[2:0] : 3'h0;
    assign irq = |(irq_status_first & irq_enable_first);

    // ************************************************************
    // storage and buffer toward the state machine
    // ************************************************************
    byte_ram #(.WIDTH(8), .ABITS(ABITS)) u_ram
    (
        .sys_clk (sys_clk),
        .wr_en   (do_push),
        .wr_addr (wr_ptr),
        .wr_data (push_data),
        .rd_addr (rd_ptr),
        .rd_data (ram_q)
    );

    pair_buffer #(.WIDTH(8)) u_buf
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .flush     (flush_pointers),
        .in_valid  (sm_pending),
        .in_ready  (),
        .in_data   (ram_q),
        .out_valid (sm_rd_valid),
        .out_ready (sm_rd_ready),
        .out_data  (sm_rd_data),
        .fill      (buf_fill)
    );

    // ************************************************************
    // pointers and count
    // ************************************************************
    // a flush also drops the word on its way to the buffer; that byte has
    // already left the count
    always @(posedge sys_clk)
    begin
        if (reset || flush_pointers)
        begin
            wr_ptr          <= {ABITS{1'b0}};
            rd_ptr          <= {ABITS{1'b0}};
            occupancy_count <= 10'h000;
            sm_pending      <= 1'b0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= rd_ptr + 1'b1;
            // push and pop together cancel out
            occupancy_count <= occupancy_count + {9'h000, do_push}
                             - {9'h000, do_pop};
            sm_pending <= pop_sm;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            depth_select        <= 1'b0;
            thresh_hi           <= THRESH_INIT[8];
            queue_threshold_low <= THRESH_INIT[7:0];
            irq_enable_first    <= ENABLE_INIT;
            irq_status_first    <= 3'h0;
            prev_near_full      <= 1'b0;
            prev_near_empty     <= 1'b0;
        end
        else
        begin
            // a depth change keeps the stored bytes; an over-filled short
            // queue reads as full until it drains
            if (wr_control)
            begin
                depth_select <= reg_wdata[`CTL_DEPTH_SEL];
                thresh_hi    <= reg_wdata[`CTL_THRESH_HI];
            end
            if (wr_thresh_low)
                queue_threshold_low <= reg_wdata;
            if (wr_irq_enable)
                irq_enable_first <= reg_wdata[2:0];
            // a new event wins over a clear in the same cycle
            irq_status_first <= (irq_status_first & ~irq_clr) | irq_set;
            prev_near_full   <= near_full_flag;
            prev_near_empty  <= near_empty_flag;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    // flush reads back as zero; the count's high bits ride along
    assign ctl_byte = {depth_select, near_full_flag, near_empty_flag,
                       1'b0, 1'b0, thresh_hi,
                       occupancy_count[9:8]};

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            rdata_reg       <= 8'h00;
            reg_rdata_valid <= 1'b0;
            host_pending    <= 1'b0;
        end
        else
        begin
            reg_rdata_valid <= reg_rd;
            host_pending    <= pop_host;
            case (reg_addr)
                `OFS_CONTROL:
                    rdata_reg <= ctl_byte;
                // data answers come from the array; an empty read shows zero
                `OFS_DATA:
                    rdata_reg <= 8'h00;
                `OFS_THRESH_LOW:
                    rdata_reg <= queue_threshold_low;
                `OFS_COUNT_LOW:
                    rdata_reg <= occupancy_count[7:0];
                `OFS_IRQ_STATUS:
                    rdata_reg <= {5'h00, irq_status_first};
                `OFS_IRQ_ENABLE:
                    rdata_reg <= {5'h00, irq_enable_first};
                default:
                    rdata_reg <= 8'h00;
            endcase
        end
    end

    // data reads come straight from the registered array output
    assign reg_rdata = host_pending ? ram_q : rdata_reg;

endmodule

`default_nettype wire

// ===== verification/shared_byte_fifo_asserts.sv
// port checker for the shared byte queue, bound to its top module.
// assumes a single sys_clk domain with synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_map.vh"
module shared_byte_fifo_asserts
#(
    parameter ABITS = 9
)
(
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rdata_valid,
    input wire logic       sm_wr_valid,
    input wire logic       sm_wr_ready,
    input wire logic [7:0] sm_wr_data,
    input wire logic       sm_fetch_en,
    input wire logic       sm_rd_valid,
    input wire logic       sm_rd_ready,
    input wire logic [7:0] sm_rd_data,
    input wire logic       irq
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire flush_wr = reg_wr && reg_addr == `OFS_CONTROL
                    && reg_wdata[`CTL_FLUSH];

    rd_answer_a: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read strobe not answered");
    answer_cause_a: assert property (reg_rdata_valid |-> $past(reg_rd))
        else $error("read answer without strobe");
    unmapped_zero_a: assert property
        (reg_rd && reg_addr > `OFS_IRQ_ENABLE |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    flush_reads_a: assert property
        (reg_rd && reg_addr == `OFS_CONTROL |=> !reg_rdata[`CTL_FLUSH])
        else $error("flush bit read back");
    flush_drops_a: assert property (flush_wr |=> !sm_rd_valid)
        else $error("prefetched word survived flush");
    host_first_a: assert property
        (reg_wr && reg_addr == `OFS_DATA |-> !sm_wr_ready)
        else $error("push accepted during host write");
    word_hold_a: assert property
        (sm_rd_valid && !sm_rd_ready && !flush_wr
        |=> sm_rd_valid && $stable(sm_rd_data))
        else $error("stalled word changed");
    fetch_cause_a: assert property
        ($rose(sm_rd_valid) |-> $past(sm_fetch_en, 2))
        else $error("word appeared without fetch");

    cover property (reg_wr && reg_rd);
    cover property (sm_rd_valid && !sm_rd_ready);
    cover property ($rose(irq));
endmodule

bind shared_byte_fifo shared_byte_fifo_asserts #(.ABITS(ABITS)) u_chk (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .sm_wr_valid(sm_wr_valid), .sm_wr_ready(sm_wr_ready),
    .sm_wr_data(sm_wr_data), .sm_fetch_en(sm_fetch_en),
    .sm_rd_valid(sm_rd_valid), .sm_rd_ready(sm_rd_ready),
    .sm_rd_data(sm_rd_data), .irq(irq));
`default_nettype wire

// ===== verification/sm_model.sv
// behavioural protocol state machine on the far side of the queue.
// assumes the bench changes its controls with non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none
module sm_model
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       push_on,
    input  wire logic       fetch_on,
    input  wire logic       stall,
    input  wire logic       sm_wr_ready,
    input  wire logic       sm_rd_valid,
    input  wire logic [7:0] sm_rd_data,
    output var  logic       sm_wr_valid = 1'b0,
    output var  logic [7:0] sm_wr_data = 8'h00,
    output var  logic       sm_fetch_en = 1'b0,
    output var  logic       sm_rd_ready = 1'b1
);
    logic [7:0] got [0:63];
    int         n_push = 0;
    int         n_got = 0;
    logic       took = 1'b0;
    logic       v;

    always @(posedge sys_clk)
    begin
        took <= sm_wr_valid && sm_wr_ready;
        if (reset)
        begin
            n_push <= 0;
            n_got <= 0;
        end
        else
        begin
            if (sm_wr_valid && sm_wr_ready)
                n_push <= n_push + 1;
            if (sm_rd_valid && sm_rd_ready && n_got < 64)
            begin
                got[n_got] <= sm_rd_data;
                n_got <= n_got + 1;
            end
        end
    end

    // a push is held until taken; an idle data bus toggles so no stale match
    always @(negedge sys_clk)
    begin
        v = (sm_wr_valid && !took) || push_on;
        sm_wr_valid <= v;
        sm_wr_data <= v ? 8'h40 + n_push[7:0] : ~sm_wr_data;
        sm_fetch_en <= fetch_on;
        sm_rd_ready <= !stall;
    end
endmodule
`default_nettype wire

// ===== verification/shared_byte_fifo_with_watermark_test.sv
// self-checking bench for the shared byte queue and its far-side model.
// assumes fifo_map.vh on the include path; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_map.vh"
module shared_byte_fifo_with_watermark_test;
    logic       sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, b;
    wire  [7:0] reg_rdata, sm_wr_data, sm_rd_data;
    wire        reg_rdata_valid, sm_wr_valid, sm_wr_ready, irq;
    wire        sm_fetch_en, sm_rd_valid, sm_rd_ready;
    logic       push_on = 0, fetch_on = 0, stall = 0;
    int         err_count = 0, n_compared = 0, seed = 96, n, k;
    logic [7:0] q[$];
    logic [8:0] th;
    logic [9:0] cap;

    always #10 sys_clk = ~sys_clk;

    shared_byte_fifo u_dut (.sys_clk(sys_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .sm_wr_valid(sm_wr_valid),
        .sm_wr_ready(sm_wr_ready), .sm_wr_data(sm_wr_data),
        .sm_fetch_en(sm_fetch_en), .sm_rd_valid(sm_rd_valid),
        .sm_rd_ready(sm_rd_ready), .sm_rd_data(sm_rd_data), .irq(irq));
    sm_model u_sm (.sys_clk(sys_clk), .reset(reset), .push_on(push_on),
        .fetch_on(fetch_on), .stall(stall), .sm_wr_ready(sm_wr_ready),
        .sm_rd_valid(sm_rd_valid), .sm_rd_data(sm_rd_data),
        .sm_wr_valid(sm_wr_valid), .sm_wr_data(sm_wr_data),
        .sm_fetch_en(sm_fetch_en), .sm_rd_ready(sm_rd_ready));

    // ************************************************************
    // helpers
    // ************************************************************
    task chk(input logic [9:0] g, input logic [9:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge sys_clk);
        reg_wr = 0;
    endtask

    // valid flag and data are checked together, one cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge sys_clk);
        reg_rd = 0;
        chk({reg_rdata_valid, 1'b0, reg_rdata}, {2'h2, e});
    endtask

    task burst(input int m);
        for (int i = 0; i < m; i++)
        begin
            @(negedge sys_clk);
            b = 8'($random(seed));
            reg_addr = `OFS_DATA;
            reg_wdata = b;
            reg_wr = 1;
            if (q.size() < cap)
                q.push_back(b);
        end
        @(negedge sys_clk);
        reg_wr = 0;
    endtask

    function logic [7:0] ctl(input logic d, input logic [9:0] c);
        logic [9:0] cp;
        cp = d ? `DEPTH_SHORT : `DEPTH_FULL;
        ctl = {d, cp - c <= {1'b0, th}, c <= {1'b0, th}, 2'h0,
               th[8], c[9:8]};
    endfunction

    // ************************************************************
    // sequence
    // ************************************************************
    initial
    begin
        repeat (12) @(negedge sys_clk);
        reset = 0;
        th = `THRESH_RESET;
        rd(`OFS_THRESH_LOW, th[7:0]);
        rd(`OFS_CONTROL, ctl(1'b0, 10'h000));
        rd(`OFS_IRQ_STATUS, 8'h01);
        wr(8'h1F, 8'hA5);
        rd(8'h1F, 8'h00);
        $display("test reset_map done");
        for (int d = 1; d >= 0; d--)
        begin
            cap = d ? `DEPTH_SHORT : `DEPTH_FULL;
            th = {~d[0], 8'($random(seed)) & 8'h3F};
            q.delete();
            wr(`OFS_CONTROL, {d[0], 3'h1, 1'b0, th[8], 2'h0});
            wr(`OFS_THRESH_LOW, th[7:0]);
            wr(`OFS_IRQ_ENABLE, 8'h07);
            wr(`OFS_IRQ_STATUS, 8'h07);
            rd(`OFS_IRQ_ENABLE, 8'h07);
            chk({9'h0, irq}, 10'h000);
            burst(cap + 1);
            rd(`OFS_COUNT_LOW, cap[7:0]);
            rd(`OFS_CONTROL, ctl(d[0], cap));
            rd(`OFS_IRQ_STATUS, 8'h06);
            chk({9'h0, irq}, 10'h001);
            repeat (2) rd(`OFS_DATA, q.pop_front());
            rd(`OFS_COUNT_LOW, 8'(cap - 2));
            wr(`OFS_CONTROL, {d[0], 3'h1, 1'b0, th[8], 2'h0});
            rd(`OFS_COUNT_LOW, 8'h00);
            rd(`OFS_DATA, 8'h00);
            rd(`OFS_COUNT_LOW, 8'h00);
            rd(`OFS_IRQ_STATUS, 8'h07);
            wr(`OFS_IRQ_STATUS, 8'h07);
            $display("test depth %0d done", d);
        end
        q.delete();
        burst(3);
        @(negedge sys_clk);
        b = 8'($random(seed));
        reg_wdata = b;
        reg_wr = 1;
        reg_rd = 1;
        @(negedge sys_clk);
        reg_wr = 0;
        reg_rd = 0;
        q.push_back(b);
        b = q.pop_front();
        chk({reg_rdata_valid, 1'b0, reg_rdata}, {2'h2, b});
        rd(`OFS_COUNT_LOW, 8'h03);
        repeat (3) rd(`OFS_DATA, q.pop_front());
        $display("test both_ways done");
        // host keeps off the data port while the state machine moves bytes
        wr(`OFS_CONTROL, 8'h10);
        push_on <= 1;
        repeat (10) @(negedge sys_clk);
        push_on <= 0;
        repeat (3) @(negedge sys_clk);
        n = u_sm.n_push;
        rd(`OFS_COUNT_LOW, 8'(n));
        stall <= 1;
        fetch_on <= 1;
        repeat (8) @(negedge sys_clk);
        rd(`OFS_COUNT_LOW, 8'(n - 2));
        repeat (40)
        begin
            @(negedge sys_clk);
            stall <= 1'($random(seed));
        end
        stall <= 0;
        for (k = 0; k < 100 && u_sm.n_got != n; k++)
            @(negedge sys_clk);
        if (k == 100)
        begin
            chk(10'(u_sm.n_got), 10'(n));
            test_done();
        end
        for (int i = 0; i < n; i++)
            chk({2'h0, u_sm.got[i]}, 10'(8'h40 + i));
        rd(`OFS_COUNT_LOW, 8'h00);
        $display("test state_machine done");
        test_done();
    end
endmodule
`default_nettype wire
